/* inc/pewc_pkg.sv */
// Purpose: Shared constants and types for the power event wake control block
// Assumes: 16-bit register access, one 125 MHz clock domain
// Notes:   Times are derived into cycle counts from the clock period
package pewc_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] PEWC_ADDR_PWR_EVT_CTRL = 8'hD4; // power_event_control
	localparam logic [7:0] PEWC_ADDR_SLEEP_WAKE   = 8'hD6; // sleep_wake_time_reg
	localparam logic [7:0] PEWC_ADDR_GLOBAL_RST   = 8'hC6; // global_reset_reg (read wakes)

	// ------------------------------------------------------------
	// Field positions of power_event_control
	// ------------------------------------------------------------
	localparam int PEWC_B_DLY_EN   = 14;
	localparam int PEWC_B_POL      = 12;
	localparam int PEWC_B_EN_HI    = 11;
	localparam int PEWC_B_EN_LO    = 8;
	localparam int PEWC_B_AUTO_WK  = 7;
	localparam int PEWC_B_WK_NORM  = 6;
	localparam int PEWC_B_CAUSE_HI = 5;
	localparam int PEWC_B_CAUSE_LO = 2;
	localparam int PEWC_B_MODE_HI  = 1;

	// Field positions of sleep_wake_time_reg
	localparam int PEWC_B_WAKE_HI  = 15;
	localparam int PEWC_B_WAKE_LO  = 8;
	localparam int PEWC_B_SLEEP_HI = 7;

	// Writable control bits (14, 12, 11:8, 7, 6, 1:0)
	localparam logic [15:0] PEWC_CTRL_WMASK = 16'h5FC3;
	localparam logic [15:0] PEWC_CTRL_RST   = 16'h0000;
	localparam logic [15:0] PEWC_SWT_RST    = 16'h080C;

	// Cause codes and interrupt status bits
	localparam logic [3:0] PEWC_CAUSE_NONE = 4'h0;
	localparam int PEWC_ISR_ENERGY = 2;
	localparam int PEWC_ISR_LINK   = 3;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int PEWC_CLK_NS     = 8;
	localparam int PEWC_WAKE_MS    = 16;
	localparam int PEWC_SLEEP_MS   = 1000;
	localparam int PEWC_NS_PER_MS  = 1000000;
	localparam int PEWC_WAKE_UNIT  = PEWC_WAKE_MS * (PEWC_NS_PER_MS / PEWC_CLK_NS);
	localparam int PEWC_SLEEP_UNIT = PEWC_SLEEP_MS * (PEWC_NS_PER_MS / PEWC_CLK_NS);

	// Power modes
	typedef enum logic [1:0] {
		PEWC_MODE_NORMAL = 2'h0,
		PEWC_MODE_ENERGY = 2'h1,
		PEWC_MODE_SOFTPD = 2'h2,
		PEWC_MODE_SAVING = 2'h3
	} pewc_mode_t;

	// Wake-on-LAN event strobes: frame, packet, link up, energy
	typedef struct packed {
		logic frame;
		logic packet;
		logic link_up;
		logic energy;
	} pewc_evt_t;

endpackage

/* src/pewc_top.sv */
// Purpose: Power mode selection, energy wake, wake cause and event output
// Assumes: Host reg port is synchronous to mclk_i; line pins are asynchronous
// Notes:   Cause field is only cleared by power-up reset or a write of ones
//
// What this block does
// - Delay enable bit 14 holds event output until clocks run and host ready.
// - Delay bit acts only while automatic wake-up bit 7 is set.
// - Polarity bit 12: one drives output active high, zero active low.
// - Bits 11..8 enable frame, packet, link-up and energy events.
// - Enabled event asserts the event output; disabled events do not.
// - Auto wake in energy mode leaves low power after energy exceeds wake time.
// - Bit 6 returns mode to normal after wake time, only with bit 7.
// - Read-only bits 5..2 report the wake cause, one sticky bit per event; several can be set at once.
// - Energy wake sets interrupt bit 2; link-up wake sets bit 3.
// - Cause clears on power-up reset or write ones; other resets keep it.
// - Clearing the cause field deasserts the event output.
// - Bits 1..0 select normal, energy detect, soft power-down, power saving.
// - Low power state in energy mode wakes on line activity or reset reg read.
// - Soft power-down wakes only on a read of the global reset register.
// - Wake time counts 16 ms units, default 8, zero is not allowed; the block accepts zero and then never expires.
// - Low power entered after no energy for go-sleep time, 1 s units, default 12.
module pewc_top #(
	parameter int WAKE_UNIT_CYC  = pewc_pkg::PEWC_WAKE_UNIT,
	parameter int SLEEP_UNIT_CYC = pewc_pkg::PEWC_SLEEP_UNIT
) (
	input  wire logic               mclk_i,
	input  wire logic               rst_b_i,         // Soft/hardware reset
	input  wire logic               por_b_i,         // Power-up reset, synchronous
	input  wire logic [7:0]         reg_addr_i,
	input  wire logic               reg_wr_i,
	input  wire logic               reg_rd_i,
	input  wire logic [15:0]        reg_wdata_i,
	output logic      [15:0]        reg_rdata_o,
	input  wire logic               energy_i,        // Line energy pin
	input  wire pewc_pkg::pewc_evt_t evt_i,          // Event strobes, same clock
	input  wire logic               clocks_ready_i,  // All clocks run, host ready
	output logic                    power_event_output_o,
	output logic                    low_power_o,
	output logic                    isr_energy_set_o,
	output logic                    isr_link_set_o,
	output logic      [1:0]         power_mode_o
);

	// ------------------------------------------------------------
	// Registers and state
	// ------------------------------------------------------------
	typedef enum logic [1:0] {PEWC_ST_NORM, PEWC_ST_LOW} pewc_pstate_t;

	logic [15:0]  ctrl_r;
	logic [3:0]   cause_r;
	logic [15:0]  swt_r;
	logic [2:0]   en_sync_r;
	pewc_pstate_t pst_r;
	logic [31:0]  unit_cnt_r;
	logic [7:0]   tick_cnt_r;
	logic         pme_r;
	logic [15:0]  rdata_r;
	logic         lowp_r;
	logic         isr_e_r;
	logic         isr_l_r;

	// ------------------------------------------------------------
	// Decoding
	// ------------------------------------------------------------
	wire logic wr_ctrl   = reg_wr_i && (reg_addr_i == pewc_pkg::PEWC_ADDR_PWR_EVT_CTRL);
	wire logic wr_swt    = reg_wr_i && (reg_addr_i == pewc_pkg::PEWC_ADDR_SLEEP_WAKE);
	wire logic host_wake = reg_rd_i && (reg_addr_i == pewc_pkg::PEWC_ADDR_GLOBAL_RST);
	wire logic auto_wk   = ctrl_r[pewc_pkg::PEWC_B_AUTO_WK];
	wire logic [1:0] mode = ctrl_r[pewc_pkg::PEWC_B_MODE_HI:0];
	wire logic [3:0] pme_en = ctrl_r[pewc_pkg::PEWC_B_EN_HI:pewc_pkg::PEWC_B_EN_LO];

	// Wake time sits in the upper byte, go-sleep time in the lower byte
	// A zero in either field never expires, so the state simply holds
	wire logic [7:0] wake_units  = swt_r[pewc_pkg::PEWC_B_WAKE_HI:pewc_pkg::PEWC_B_WAKE_LO];
	wire logic [7:0] sleep_units = swt_r[pewc_pkg::PEWC_B_SLEEP_HI:0];

	// Energy level agreed by the second and third synchroniser stages
	wire logic energy_ok = en_sync_r[1] & en_sync_r[2];
	wire logic no_energy = ~en_sync_r[1] & ~en_sync_r[2];
	wire logic in_ed     = (mode == pewc_mod_e(pewc_pkg::PEWC_MODE_ENERGY));
	wire logic in_low    = (pst_r == PEWC_ST_LOW);

	// Qualifying condition being timed: energy while low, silence while normal
	wire logic timing_cond = in_low ? energy_ok : no_energy;
	wire logic [7:0] limit = in_low ? wake_units : sleep_units;
	wire logic [31:0] unit_len = in_low ? WAKE_UNIT_CYC : SLEEP_UNIT_CYC;
	wire logic unit_done = (unit_cnt_r == unit_len - 32'h1);
	wire logic time_done = unit_done && (tick_cnt_r == limit - 8'h01) && (limit != 8'h00);

	// Line wake needs auto wake-up; host read always wakes
	wire logic line_wake = in_ed && in_low && auto_wk && timing_cond && time_done;
	wire logic go_sleep  = in_ed && !in_low && timing_cond && time_done;
	wire logic wake_norm = line_wake && ctrl_r[pewc_pkg::PEWC_B_WK_NORM];
	wire logic wake_softpd = host_wake && (mode == pewc_mod_e(pewc_pkg::PEWC_MODE_SOFTPD));
	wire logic wake_host_ed = host_wake && in_ed && in_low;

	// Cause events: energy wake from line plus external event strobes
	wire logic [3:0] evt_vec = {evt_i.frame, evt_i.packet, evt_i.link_up, line_wake};
	wire logic [3:0] w1c     = wr_ctrl ? reg_wdata_i[pewc_pkg::PEWC_B_CAUSE_HI:
		pewc_pkg::PEWC_B_CAUSE_LO] : 4'h0;
	wire logic [3:0] cause_nxt = (cause_r & ~w1c) | evt_vec; // Set wins over clear

	// Output assertion with optional delay while auto wake is on
	wire logic hold_off = ctrl_r[pewc_pkg::PEWC_B_DLY_EN] && auto_wk && !clocks_ready_i;
	wire logic pme_act  = ((cause_nxt & pme_en) != pewc_pkg::PEWC_CAUSE_NONE) && !hold_off;
	wire logic pme_pin  = ctrl_r[pewc_pkg::PEWC_B_POL] ? pme_act : !pme_act;

	// Mode next value: host write, or wake to normal
	wire logic [15:0] ctrl_wr  = (ctrl_r & ~pewc_pkg::PEWC_CTRL_WMASK) |
		(reg_wdata_i & pewc_pkg::PEWC_CTRL_WMASK);
	wire logic [15:0] ctrl_nxt = (wake_norm || wake_softpd) ?
		{ctrl_r[15:2], pewc_pkg::PEWC_MODE_NORMAL} : ctrl_r;

	// Read data mux
	wire logic [15:0] rdata_nxt =
		(reg_addr_i == pewc_pkg::PEWC_ADDR_PWR_EVT_CTRL) ?
		((ctrl_r & pewc_pkg::PEWC_CTRL_WMASK) | {10'h000, cause_r, 2'h0}) :
		(reg_addr_i == pewc_pkg::PEWC_ADDR_SLEEP_WAKE) ? swt_r : 16'h0000;

	// Power state next value: sleep after silence, wake on line or host read
	pewc_pstate_t pst_nxt;
	always_comb begin
		pst_nxt = pst_r;
		case (pst_r)
			PEWC_ST_NORM: begin
				if (go_sleep) begin
					pst_nxt = PEWC_ST_LOW;
				end
			end
			PEWC_ST_LOW: begin
				if (line_wake || wake_host_ed) begin
					pst_nxt = PEWC_ST_NORM;
				end
			end
			default: begin
				pst_nxt = PEWC_ST_NORM;
			end
		endcase
	end

	// Turns a mode code into its raw two bits for comparison with the field
	// Kept as a function since two decodes compare against mode codes
	function automatic logic [1:0] pewc_mod_e(input pewc_pkg::pewc_mode_t m);
		return m;
	endfunction

	// ------------------------------------------------------------
	// Cause field, survives soft reset, cleared by power-up reset
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!por_b_i) begin
			cause_r <= pewc_pkg::PEWC_CAUSE_NONE;
		end else begin
			cause_r <= cause_nxt;
		end
	end

	// Energy pin synchroniser
	// Three stages; only the agreement of the last two is acted upon
	always_ff @(posedge mclk_i) begin
		en_sync_r <= {en_sync_r[1:0], energy_i};
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i || !por_b_i) begin
			ctrl_r <= pewc_pkg::PEWC_CTRL_RST;
			swt_r  <= pewc_pkg::PEWC_SWT_RST;
		end else begin
			ctrl_r <= wr_ctrl ? ctrl_wr : ctrl_nxt;
			if (wr_swt) begin
				swt_r <= reg_wdata_i;
			end
		end
	end

	// ------------------------------------------------------------
	// Energy detect power state and timers
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i || !por_b_i || !in_ed) begin
			pst_r      <= PEWC_ST_NORM;
			unit_cnt_r <= 32'h0;
			tick_cnt_r <= 8'h00;
		end else if (line_wake || wake_host_ed || go_sleep || !timing_cond) begin
			pst_r      <= pst_nxt;
			unit_cnt_r <= 32'h0;
			tick_cnt_r <= 8'h00;
		end else begin
			unit_cnt_r <= unit_done ? 32'h0 : unit_cnt_r + 32'h1;
			tick_cnt_r <= unit_done ? tick_cnt_r + 8'h01 : tick_cnt_r;
		end
	end

	// ------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i || !por_b_i) begin
			rdata_r <= 16'h0000;
			pme_r   <= 1'b1;
			lowp_r  <= 1'b0;
			isr_e_r <= 1'b0;
			isr_l_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			pme_r   <= pme_pin;
			lowp_r  <= (in_ed && in_low && !line_wake && !wake_host_ed) || go_sleep;
			isr_e_r <= line_wake;
			isr_l_r <= evt_i.link_up;
		end
	end

	assign reg_rdata_o          = rdata_r;
	assign power_event_output_o = pme_r;
	assign low_power_o          = lowp_r;
	assign isr_energy_set_o     = isr_e_r;
	assign isr_link_set_o       = isr_l_r;
	assign power_mode_o         = ctrl_r[pewc_pkg::PEWC_B_MODE_HI:0];

endmodule // pewc_top

/* sim/pewc_checker.sv */
// Purpose: Port checks for the power event wake control block
// Assumes: One clock, synchronous active low resets
// Notes:   Shadows the control word from host writes
module pewc_checker (
	input wire logic                mclk_i,
	input wire logic                rst_b_i,
	input wire logic                por_b_i,
	input wire logic [7:0]          reg_addr_i,
	input wire logic                reg_wr_i,
	input wire logic                reg_rd_i,
	input wire logic [15:0]         reg_wdata_i,
	input wire logic [15:0]         reg_rdata_o,
	input wire pewc_pkg::pewc_evt_t evt_i,
	input wire logic                clocks_ready_i,
	input wire logic                power_event_output_o,
	input wire logic                low_power_o,
	input wire logic                isr_link_set_o,
	input wire logic [1:0]          power_mode_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] ctl_r;
	wire         ctl_wr = reg_wr_i && reg_addr_i == 8'hD4;
	wire         host_wk = reg_rd_i && reg_addr_i == 8'hC6;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i || !por_b_i);
	// Shadow control word
	always_ff @(posedge mclk_i) begin
		ctl_r <= (!rst_b_i || !por_b_i) ? 16'h0000 : (ctl_wr ? reg_wdata_i : ctl_r);
	end
	link_isr_a: assert property (evt_i.link_up |=> isr_link_set_o)
		else $error("link wake gave no status pulse");
	pme_on_a: assert property (evt_i.link_up && ctl_r[9] && !ctl_wr && !(ctl_r[14] && ctl_r[7])
		|=> power_event_output_o == ctl_r[12]) else $error("enabled event not on pin");
	pme_hold_a: assert property ((ctl_r[14] && ctl_r[7] && !clocks_ready_i && !ctl_wr) [*2]
		|-> power_event_output_o != ctl_r[12]) else $error("pin not held off");
	clr_pme_a: assert property (ctl_wr && reg_wdata_i[5:2] == 4'hF && evt_i == 4'h0 ##1
		(evt_i == 4'h0 && !ctl_wr) |=> power_event_output_o != ctl_r[12]) else $error("pin kept");
	mode_wr_a: assert property (ctl_wr |=> power_mode_o == ctl_r[1:0])
		else $error("mode not taken");
	pd_stay_a: assert property (power_mode_o == 2'h2 && !host_wk && !ctl_wr |=> power_mode_o == 2'h2)
		else $error("soft power-down left");
	pd_wake_a: assert property (power_mode_o == 2'h2 && host_wk && !ctl_wr |=> power_mode_o == 2'h0)
		else $error("host read did not wake");
	ctl_rd_a: assert property (reg_addr_i == 8'hD4 && !ctl_wr
		|=> (reg_rdata_o & 16'h5FC0) == (ctl_r & 16'h5FC0)) else $error("control readback");
	low_ed_a: assert property ($rose(low_power_o) |-> power_mode_o == 2'h1)
		else $error("low power outside energy mode");
endmodule // pewc_checker
bind pewc_top pewc_checker i_pewc_checker (.*);

/* sim/pewc_line.sv */
// Purpose: Line side model making the energy level
// Assumes: Carrier request comes from the bench
// Notes:   One clock of line lag, no energy unless asked
module pewc_line (
	input  wire logic mclk_i,
	input  wire logic carrier_i,
	output logic      energy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Energy follows the carrier
	always_ff @(posedge mclk_i) begin
		energy_o <= carrier_i;
	end
endmodule // pewc_line

/* sim/test_power_event_wake_control.sv */
// Purpose: Self-checking bench for the power event wake control block
// Assumes: Wake unit 4 cycles, sleep unit 8 cycles
// Notes:   Each step drives the host port, line and events, then checks one observed item unless its index is 6 or more
module test_power_event_wake_control;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] CT = 8'hD4, TM = 8'hD6, GR = 8'hC6;
	logic mclk_i = 1'b0, rst_b_i = 1'b0, por_b_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic carrier = 1'b0, clocks_ready_i = 1'b1, energy_i, power_event_output, low_pw, isr_en, isr_ln;
	logic isr_seen = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [15:0] reg_wdata_i = 16'h0000, rdata;
	logic [1:0] mode;
	pewc_pkg::pewc_evt_t evt_i = 4'h0;
	int fail_count = 0, comparisons = 0;
	string nm[6] = '{"pin", "cause", "rdata", "mode", "low", "irq"};
	// Clock and energy status capture
	always #4 mclk_i = ~mclk_i;
	always @(posedge mclk_i) if (isr_en) isr_seen <= 1'b1;
	pewc_line i_pewc_line (.mclk_i(mclk_i), .carrier_i(carrier), .energy_o(energy_i));
	pewc_top #(.WAKE_UNIT_CYC(4), .SLEEP_UNIT_CYC(8)) i_pewc_top (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.por_b_i(por_b_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata), .energy_i(energy_i), .evt_i(evt_i),
		.clocks_ready_i(clocks_ready_i), .power_event_output_o(power_event_output), .low_power_o(low_pw),
		.isr_energy_set_o(isr_en), .isr_link_set_o(isr_ln), .power_mode_o(mode));
	task automatic chk(input string n, input logic [15:0] s, e);
		comparisons++;
		if (s !== e) $display("unexpected %s expected %h seen %h", n, e, s);
		if (s !== e) fail_count++;
	endtask
	// One step: {wr,rd}, {carrier,ready}, events, extra wait, observed item, expected
	task automatic st(input logic [7:0] a, input logic [15:0] d, input logic [1:0] wr, cr,
		input logic [3:0] e, input int n, s, input logic [15:0] x);
		logic [15:0] ob[6];
		@(posedge mclk_i);
		{reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, evt_i, carrier, clocks_ready_i} <= {a, d, wr, e, cr};
		@(posedge mclk_i);
		{reg_wr_i, reg_rd_i, evt_i} <= 6'h00;
		repeat (n + 2) @(posedge mclk_i);
		#1;
		ob = '{power_event_output, rdata[5:2], rdata, mode, low_pw, isr_seen};
		if (s < 6) chk(nm[s], ob[s], x);
	endtask
	task automatic rst(input logic p);
		@(posedge mclk_i);
		{rst_b_i, por_b_i} <= {1'b0, ~p};
		repeat (8) @(posedge mclk_i);
		{rst_b_i, por_b_i} <= 2'h3;
	endtask
	task automatic t_events();
		st(CT, 16'h0000, 2'h0, 2'h1, 4'h0, 0, 2, 16'h0000);
		st(TM, 16'h0000, 2'h0, 2'h1, 4'h0, 0, 2, 16'h080C);
		st(CT, 16'h0000, 2'h0, 2'h1, 4'h0, 0, 0, 16'h0001);
		for (int i = 1; i < 4; i++) begin
			st(CT, 16'h1000 | (16'h0100 << i), 2'h2, 2'h1, 4'h0, 0, 9, 16'h0000);
			st(CT, 16'h0000, 2'h0, 2'h1, 4'h1 << i, 0, 0, 16'h0001);
			st(CT, 16'h0000, 2'h0, 2'h1, 4'h0, 4, 1, 16'h0001 << i);
			st(CT, 16'h103C, 2'h2, 2'h1, 4'h0, 0, 0, 16'h0000);
			st(CT, 16'h0000, 2'h0, 2'h1, 4'h1 << i, 0, 0, 16'h0000);
			st(CT, 16'h003C, 2'h2, 2'h1, 4'h0, 0, 1, 16'h0000);
		end
		st(CT, 16'h0200, 2'h2, 2'h1, 4'h2, 0, 9, 16'h0000);
		rst(1'b0);
		st(CT, 16'h0000, 2'h0, 2'h1, 4'h0, 0, 1, 16'h0002);
		rst(1'b1);
		st(CT, 16'h0000, 2'h0, 2'h1, 4'h0, 0, 1, 16'h0000);
	endtask
	task automatic t_delay();
		st(CT, 16'h5280, 2'h2, 2'h1, 4'h0, 0, 9, 16'h0000);
		st(CT, 16'h0000, 2'h0, 2'h0, 4'h2, 0, 0, 16'h0000);
		st(CT, 16'h0000, 2'h0, 2'h1, 4'h0, 0, 0, 16'h0001);
		st(CT, 16'h523C, 2'h2, 2'h1, 4'h0, 0, 9, 16'h0000);
		st(CT, 16'h0000, 2'h0, 2'h0, 4'h2, 0, 0, 16'h0001);
		st(CT, 16'h003C, 2'h2, 2'h1, 4'h0, 0, 0, 16'h0001);
	endtask
	task automatic t_wake();
		st(TM, 16'h0101, 2'h2, 2'h1, 4'h0, 0, 9, 16'h0000);
		st(CT, 16'h11C1, 2'h2, 2'h1, 4'h0, 24, 4, 16'h0001);
		st(CT, 16'h0000, 2'h0, 2'h3, 4'h0, 16, 4, 16'h0000);
		st(CT, 16'h0000, 2'h0, 2'h3, 4'h0, 0, 3, 16'h0000);
		st(CT, 16'h0000, 2'h0, 2'h3, 4'h0, 0, 5, 16'h0001);
		st(CT, 16'h0000, 2'h0, 2'h3, 4'h0, 0, 1, 16'h0001);
		st(CT, 16'h003E, 2'h2, 2'h3, 4'h0, 40, 3, 16'h0002);
		st(GR, 16'h0000, 2'h1, 2'h1, 4'h0, 0, 3, 16'h0000);
		st(CT, 16'h0001, 2'h2, 2'h1, 4'h0, 24, 4, 16'h0001);
		st(GR, 16'h0000, 2'h1, 2'h1, 4'h0, 0, 4, 16'h0000);
		st(CT, 16'h0003, 2'h2, 2'h1, 4'h0, 0, 3, 16'h0003);
	endtask
	task automatic final_report();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Watchdog: the steps need well under 2000 cycles
	initial begin
		#50us;
		fail_count++;
		final_report();
	end
	// Main sequence
	initial begin
		rst(1'b1);
		t_events();
		t_delay();
		t_wake();
		final_report();
	end
endmodule // test_power_event_wake_control
